// ==== hdl/bchs_pkg.sv ====
// package: descriptor layout and constants for the branch hazard stall block
package bchs_pkg;

   // ****************************************************************
   // pipeline geometry
   // ****************************************************************
   localparam int STAGES    = 5;
   localparam int ST_FETCH1 = 0;
   localparam int ST_FETCH2 = 1;
   localparam int ST_DECODE = 2;
   localparam int ST_ADDR   = 3;
   localparam int ST_EXEC   = 4;
   localparam int TAG_W_DEF = 8;
   localparam int ID_W      = 4;

   // ****************************************************************
   // instruction descriptor bit positions
   // ****************************************************************
   localparam int P_AGLOAD  = 0;   // loads an address_generator register
   localparam int P_INDBR   = 1;   // indirect jump/call target from agReadId
   localparam int P_TAKEN   = 2;   // taken jump, call or return
   localparam int P_COND    = 3;   // conditional on a flag
   localparam int P_UNIT    = 4;   // two bits, bchs_unit_t
   localparam int P_BRANCH  = 6;   // instruction is a branch
   localparam int P_SETALU  = 7;
   localparam int P_SETMUL  = 8;
   localparam int P_SETBTF  = 9;
   localparam int P_LCECHG  = 10;  // changes loop_count_expired_cond
   localparam int P_STATWR  = 11;  // writes arith_status_x/y or flags
   localparam int P_CPM     = 12;  // conditional post-modify of index_register
   localparam int P_IDXUSE  = 13;  // address generation from / read of index
   localparam int P_FPMUL   = 14;
   localparam int P_FXUSE   = 15;
   localparam int P_WRID    = 16;  // ID_W bits
   localparam int P_RDID    = 20;  // ID_W bits
   localparam int P_SDIST   = 24;  // two bits, status-write distance
   localparam int DESC_W    = 26;

   // distance of a status write seen when a post-modify leaves decode
   localparam logic [1:0] SDIST_ADJ  = 2'h1;
   localparam logic [1:0] SDIST_GAP  = 2'h2;
   localparam logic [1:0] SDIST_FAR  = 2'h3;
   localparam logic [2:0] SDIST_CLR  = 3'h4;

   typedef logic [DESC_W-1:0] bchs_desc_t;

   typedef enum logic [1:0] {
      UNIT_ALU  = 2'b00,
      UNIT_MUL  = 2'b01,
      UNIT_BIT  = 2'b10,
      UNIT_LOOP = 2'b11
   } bchs_unit_t;

endpackage : bchs_pkg

// ==== hdl/bchs_core.sv ====
// module: five-stage pipeline hazard detection and stall control
// Operation
// RULE_01 - indirect branch right after its ag register load holds two cycles
// RULE_02 - one unrelated instruction between load and branch gives one stall
// RULE_03 - branch reads ag register in decode; loads complete in execute
// RULE_04 - taken jump or call turns three younger instructions into nops
// RULE_05 - conditional branch after a flag-setting compute stalls one cycle
// RULE_06 - return also costs three cycles, younger fetches become nops
// RULE_07 - multiplier-flag branch after multiply stalls one extra cycle
// RULE_08 - loop-count branch after loop-condition change stalls two cycles
// RULE_09 - non-branch conditioned on loop count stalls only one cycle
// RULE_10 - ordinary loop-back decrement never stalls loop-count branches
// RULE_11 - status write, post-modify, index use back to back: two stalls
// RULE_12 - one gap around post-modify gives one stall, two gaps none
// RULE_13 - flag dependency checked per unit: alu, multiplier, bit test
// RULE_14 - overlapping hazards may stall more than the minimum
// RULE_15 - fixed-point compute right after float multiply stalls one cycle
// RULE_16 - producer and older proceed; dependent and younger are held
// RULE_17 - stages are fetch1, fetch2, decode, address, execute
// RULE_18 - held stages keep contents, a bubble goes on to address
`timescale 1ns/1ps

module bchs_core #(
   parameter int TAG_W = bchs_pkg::TAG_W_DEF
) (
   input  wire logic                     sys_clk,
   input  wire logic                     rst_n,
   input  wire logic                     fetchValid,
   input  wire logic [TAG_W-1:0]         fetchTag,
   input  wire logic                     agLoad,
   input  wire logic [bchs_pkg::ID_W-1:0] agLoadId,
   input  wire logic [bchs_pkg::ID_W-1:0] agReadId,
   input  wire logic                     indirectBranch,
   input  wire logic                     branchTaken,
   input  wire logic                     isBranch,
   input  wire logic                     condValid,
   input  wire bchs_pkg::bchs_unit_t     condUnit,
   input  wire logic                     setsAluFlag,
   input  wire logic                     setsMulFlag,
   input  wire logic                     setsBitTestFlag,
   input  wire logic                     loopCondChange,
   input  wire logic                     statusWrite,
   input  wire logic                     condPostModify,
   input  wire logic                     indexUse,
   input  wire logic                     floatMul,
   input  wire logic                     fixedUse,
   output logic                          pipeStall,
   output logic                          fetchRedirect,
   output logic                          execValid,
   output logic [TAG_W-1:0]              execTag
);
   import bchs_pkg::*;
   default clocking sysCb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   // ****************************************************************
   // stage state, index 0 is fetch1 and 4 is execute
   // ****************************************************************
   logic             vld_r  [STAGES];                          // RULE_17
   bchs_desc_t       desc_r [STAGES];
   logic [TAG_W-1:0] tag_r  [STAGES];
   logic             vld_nxt  [STAGES];
   bchs_desc_t       desc_nxt [STAGES];
   logic [TAG_W-1:0] tag_nxt  [STAGES];
   logic             stall_r;
   logic             redirect_r;
   bchs_desc_t       descIn;
   logic             leaveDec;
   logic             kill;

   // ****************************************************************
   // hazard decode, shared by the stall register and nothing else
   // ****************************************************************
   function automatic logic hazardOf(
      input logic       vd,
      input bchs_desc_t d,
      input logic       va,
      input bchs_desc_t a,
      input logic       ve,
      input bchs_desc_t e);
      logic       h;
      bchs_unit_t u;
      logic       sameA;
      logic       sameE;
      h = 1'b0;
      u = bchs_unit_t'(d[P_UNIT +: 2]);
      sameA = a[P_WRID +: ID_W] == d[P_RDID +: ID_W];
      sameE = e[P_WRID +: ID_W] == d[P_RDID +: ID_W];
      if (vd) begin
         // ag read in decode against a load not yet through execute
         if (d[P_INDBR] && ((va && a[P_AGLOAD] && sameA)   // RULE_01 RULE_02
                        || (ve && e[P_AGLOAD] && sameE)))  // RULE_03
            h = 1'b1;
         if (d[P_COND] && d[P_BRANCH]) begin
            case (u)                                          // RULE_13
               UNIT_ALU: h = h | (va && a[P_SETALU]);         // RULE_05
               UNIT_BIT: h = h | (va && a[P_SETBTF]);         // RULE_05
               UNIT_MUL: h = h | (va && a[P_SETMUL])
                               | (ve && e[P_SETMUL]);         // RULE_07
               default:  h = h;
            endcase
         end
         // only explicit loop-condition writers count, never loop-back
         if (d[P_COND] && u == UNIT_LOOP) begin               // RULE_10
            if (va && a[P_LCECHG])                            // RULE_09
               h = 1'b1;
            if (d[P_BRANCH] && ve && e[P_LCECHG])             // RULE_08
               h = 1'b1;
         end
         // stall while status-to-use distance is below four
         if (d[P_IDXUSE]) begin
            if (va && a[P_CPM]                                // RULE_11 RULE_12
                && a[P_RDID +: ID_W] == d[P_RDID +: ID_W]
                && ({1'b0, a[P_SDIST +: 2]} + 3'h1) < SDIST_CLR)
               h = 1'b1;
            if (ve && e[P_CPM]                                // RULE_11 RULE_12
                && e[P_RDID +: ID_W] == d[P_RDID +: ID_W]
                && ({1'b0, e[P_SDIST +: 2]} + 3'h2) < SDIST_CLR)
               h = 1'b1;
         end
         if (d[P_FXUSE] && va && a[P_FPMUL])                  // RULE_15
            h = 1'b1;
      end
      // causes are ored, so overlapping ones are not trimmed
      return h;                                               // RULE_14
   endfunction : hazardOf

   // ****************************************************************
   // incoming descriptor
   // ****************************************************************
   always_comb begin
      descIn = '0;
      descIn[P_AGLOAD]         = agLoad;
      descIn[P_INDBR]          = indirectBranch;
      descIn[P_TAKEN]          = branchTaken;
      descIn[P_COND]           = condValid;
      descIn[P_UNIT +: 2]      = condUnit;
      descIn[P_BRANCH]         = isBranch;
      descIn[P_SETALU]         = setsAluFlag;
      descIn[P_SETMUL]         = setsMulFlag;
      descIn[P_SETBTF]         = setsBitTestFlag;
      descIn[P_LCECHG]         = loopCondChange;
      descIn[P_STATWR]         = statusWrite;
      descIn[P_CPM]            = condPostModify;
      descIn[P_IDXUSE]         = indexUse;
      descIn[P_FPMUL]          = floatMul;
      descIn[P_FXUSE]          = fixedUse;
      descIn[P_WRID +: ID_W]   = agLoadId;
      descIn[P_RDID +: ID_W]   = agReadId;
   end

   // ****************************************************************
   // next stage contents
   // ****************************************************************
   assign leaveDec = vld_r[ST_DECODE] && !stall_r;
   assign kill     = leaveDec && desc_r[ST_DECODE][P_TAKEN];  // RULE_04 RULE_06

   always_comb begin
      for (int i = 0; i < STAGES; i++) begin
         vld_nxt[i]  = vld_r[i];
         desc_nxt[i] = desc_r[i];
         tag_nxt[i]  = tag_r[i];
      end
      // producer in address always moves on to execute
      vld_nxt[ST_EXEC]  = vld_r[ST_ADDR];                     // RULE_16
      desc_nxt[ST_EXEC] = desc_r[ST_ADDR];
      tag_nxt[ST_EXEC]  = tag_r[ST_ADDR];
      if (stall_r) begin
         vld_nxt[ST_ADDR]  = 1'b0;                            // RULE_18
         desc_nxt[ST_ADDR] = '0;
         tag_nxt[ST_ADDR]  = '0;
      end else begin
         vld_nxt[ST_ADDR]  = vld_r[ST_DECODE];
         desc_nxt[ST_ADDR] = desc_r[ST_DECODE];
         tag_nxt[ST_ADDR]  = tag_r[ST_DECODE];
         if (vld_r[ST_ADDR] && desc_r[ST_ADDR][P_STATWR])
            desc_nxt[ST_ADDR][P_SDIST +: 2] = SDIST_ADJ;      // RULE_12
         else if (vld_r[ST_EXEC] && desc_r[ST_EXEC][P_STATWR])
            desc_nxt[ST_ADDR][P_SDIST +: 2] = SDIST_GAP;
         else
            desc_nxt[ST_ADDR][P_SDIST +: 2] = SDIST_FAR;
         // the three fetched behind a taken branch become nops
         vld_nxt[ST_DECODE]  = vld_r[ST_FETCH2] && !kill;     // RULE_04 RULE_06
         desc_nxt[ST_DECODE] = kill ? '0 : desc_r[ST_FETCH2];
         tag_nxt[ST_DECODE]  = tag_r[ST_FETCH2];
         vld_nxt[ST_FETCH2]  = vld_r[ST_FETCH1] && !kill;
         desc_nxt[ST_FETCH2] = kill ? '0 : desc_r[ST_FETCH1];
         tag_nxt[ST_FETCH2]  = tag_r[ST_FETCH1];
         vld_nxt[ST_FETCH1]  = fetchValid && !kill;
         desc_nxt[ST_FETCH1] = kill ? '0 : descIn;
         tag_nxt[ST_FETCH1]  = fetchTag;
      end
   end

   // ****************************************************************
   // stage registers
   // ****************************************************************
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < STAGES; i++) begin
            vld_r[i]  <= 1'b0;
            desc_r[i] <= '0;
            tag_r[i]  <= '0;
         end
      end else begin
         for (int i = 0; i < STAGES; i++) begin
            vld_r[i]  <= vld_nxt[i];
            desc_r[i] <= desc_nxt[i];
            tag_r[i]  <= tag_nxt[i];
         end
      end
   end

   // ****************************************************************
   // stall decided from next contents, redirect from current kill; both are flops
   // ****************************************************************
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)
         stall_r <= 1'b0;
      else
         stall_r <= hazardOf(vld_nxt[ST_DECODE], desc_nxt[ST_DECODE],
                             vld_nxt[ST_ADDR], desc_nxt[ST_ADDR],
                             vld_nxt[ST_EXEC], desc_nxt[ST_EXEC]);  // RULE_16
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)
         redirect_r <= 1'b0;
      else
         redirect_r <= kill;                                  // RULE_04
   end

   assign pipeStall     = stall_r;
   assign fetchRedirect = redirect_r;
   assign execValid     = vld_r[ST_EXEC];
   assign execTag       = tag_r[ST_EXEC];

   // ****************************************************************
   // checks
   // ****************************************************************
   a_decode_held: assert property (                        // RULE_18
      stall_r && vld_r[ST_DECODE] |=> vld_r[ST_DECODE]
         && tag_r[ST_DECODE] == $past(tag_r[ST_DECODE]))
      else $error("decode changed during stall");
   a_bubble_fwd: assert property (                         // RULE_18
      stall_r |=> !vld_r[ST_ADDR])
      else $error("no bubble after stall");
   a_producer_moves: assert property (                     // RULE_16
      stall_r && vld_r[ST_ADDR] |=> execValid
         && execTag == $past(tag_r[ST_ADDR]))
      else $error("producer held during stall");
   a_agload_two: assert property (                         // RULE_01
      vld_r[ST_DECODE] && desc_r[ST_DECODE][P_INDBR]
      && vld_r[ST_ADDR] && desc_r[ST_ADDR][P_AGLOAD]
      && desc_r[ST_ADDR][P_WRID +: ID_W] == desc_r[ST_DECODE][P_RDID +: ID_W]
      |-> stall_r [*2])
      else $error("ag load branch not held two cycles");
   a_agload_gap: assert property (                         // RULE_02
      vld_r[ST_DECODE] && desc_r[ST_DECODE][P_INDBR]
      && vld_r[ST_EXEC] && desc_r[ST_EXEC][P_AGLOAD]
      && desc_r[ST_EXEC][P_WRID +: ID_W] == desc_r[ST_DECODE][P_RDID +: ID_W]
      |-> stall_r)
      else $error("ag load gap stall missing");
   a_alu_flag: assert property (                           // RULE_05
      vld_r[ST_DECODE] && desc_r[ST_DECODE][P_COND]
      && desc_r[ST_DECODE][P_BRANCH]
      && desc_r[ST_DECODE][P_UNIT +: 2] == UNIT_ALU
      && vld_r[ST_ADDR] && desc_r[ST_ADDR][P_SETALU] |-> stall_r)
      else $error("alu flag stall missing");
   a_mul_extra: assert property (                          // RULE_07
      vld_r[ST_DECODE] && desc_r[ST_DECODE][P_COND]
      && desc_r[ST_DECODE][P_BRANCH]
      && desc_r[ST_DECODE][P_UNIT +: 2] == UNIT_MUL
      && vld_r[ST_ADDR] && desc_r[ST_ADDR][P_SETMUL] |-> stall_r [*2])
      else $error("multiplier flag stall too short");
   a_loop_branch: assert property (                        // RULE_08
      vld_r[ST_DECODE] && desc_r[ST_DECODE][P_COND]
      && desc_r[ST_DECODE][P_BRANCH]
      && desc_r[ST_DECODE][P_UNIT +: 2] == UNIT_LOOP
      && vld_r[ST_ADDR] && desc_r[ST_ADDR][P_LCECHG] |-> stall_r [*2])
      else $error("loop count branch stall too short");
   a_fix_after_fp: assert property (                       // RULE_15
      vld_r[ST_DECODE] && desc_r[ST_DECODE][P_FXUSE]
      && vld_r[ST_ADDR] && desc_r[ST_ADDR][P_FPMUL] |-> stall_r)
      else $error("fixed after float stall missing");
   a_branch_squash: assert property (                      // RULE_04
      leaveDec && desc_r[ST_DECODE][P_TAKEN] |=> fetchRedirect
         && !vld_r[ST_DECODE] && !vld_r[ST_FETCH2] && !vld_r[ST_FETCH1]
         ##1 !vld_r[ST_DECODE] && !vld_r[ST_FETCH2]
         ##1 !vld_r[ST_DECODE])
      else $error("three nops not inserted after branch");

endmodule : bchs_core

// ==== tb/test_bchs_core.sv ====
// testbench: self-checking stall count and order tests of the hazard block
`timescale 1ns/1ps

module test_bchs_core;
   import bchs_pkg::*;

   // ****************************************************************
   // stimulus and observation
   // ****************************************************************
   localparam int TW = TAG_W_DEF;
   localparam logic [13:0] M_LD = 14'h0001, M_IND = 14'h0002;
   localparam logic [13:0] M_TKN = 14'h0004, M_BR = 14'h0008;
   localparam logic [13:0] M_CND = 14'h0010, M_SALU = 14'h0020;
   localparam logic [13:0] M_LCC = 14'h0100, M_SW = 14'h0200;
   localparam logic [13:0] M_CPM = 14'h0400, M_IDX = 14'h0800;
   localparam logic [13:0] M_FPM = 14'h1000, M_FXU = 14'h2000;

   logic            sysClk = 1'b0;
   logic            rstN = 1'b0;
   logic            fetchValid = 1'b0;
   logic [TW-1:0]   fetchTag = '0;
   logic [13:0]     fl = '0;
   bchs_unit_t      condUnit = UNIT_ALU;
   logic [ID_W-1:0] agLoadId = '0;
   logic [ID_W-1:0] agReadId = '0;
   logic            pipeStall;
   logic            fetchRedirect;
   logic            execValid;
   logic [TW-1:0]   execTag;
   int              err_count = 0;
   int              compares = 0;
   int              stallCnt;
   int              redirCnt;
   logic [TW-1:0]   nextTag = 8'h01;
   logic [TW-1:0]   expQ[$];
   logic [TW-1:0]   tagQ[$];

   always #5 sysClk = ~sysClk;

   bchs_core #(.TAG_W(TW)) dut (
      .sys_clk(sysClk), .rst_n(rstN), .fetchValid(fetchValid),
      .fetchTag(fetchTag), .agLoad(fl[0]), .agLoadId(agLoadId),
      .agReadId(agReadId), .indirectBranch(fl[1]), .branchTaken(fl[2]),
      .isBranch(fl[3]), .condValid(fl[4]), .condUnit(condUnit),
      .setsAluFlag(fl[5]), .setsMulFlag(fl[6]), .setsBitTestFlag(fl[7]),
      .loopCondChange(fl[8]), .statusWrite(fl[9]),
      .condPostModify(fl[10]), .indexUse(fl[11]), .floatMul(fl[12]),
      .fixedUse(fl[13]), .pipeStall(pipeStall),
      .fetchRedirect(fetchRedirect), .execValid(execValid),
      .execTag(execTag));

   // flops are read before their own edge updates land
   always @(posedge sysClk) begin
      if (rstN && execValid === 1'b1) tagQ.push_back(execTag);
      if (rstN && fetchRedirect === 1'b1) redirCnt++;
      if (rstN && pipeStall === 1'b1) stallCnt++;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: seen %0h expected %0h", $time,
                  seen, exp);
      end
   endtask : check

   task automatic summarize;
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : summarize

   // offer one instruction; returns at the edge that takes it
   task automatic issue(input logic [13:0] f, input bchs_unit_t u,
                        input logic [3:0] ld, input logic [3:0] rd,
                        input bit keep = 1);
      fetchValid <= 1'b1;
      fetchTag   <= nextTag;
      fl         <= f;
      condUnit   <= u;
      agLoadId   <= ld;
      agReadId   <= rd;
      if (keep) expQ.push_back(nextTag);
      nextTag++;
      #1;
      while (pipeStall === 1'b1) begin
         @(posedge sysClk);
         #1;
      end
      @(posedge sysClk);
   endtask : issue

   task automatic gap;
      issue(14'h0000, UNIT_ALU, 4'h0, 4'h0);
   endtask : gap

   task automatic start;
      stallCnt = 0;
      redirCnt = 0;
      expQ.delete();
      tagQ.delete();
   endtask : start

   // drain, then judge stall count and the executed sequence
   task automatic finish_test(input string name, input int expStall,
                              input int expRedir = 0);
      fetchValid <= 1'b0;
      fl         <= '0;
      repeat (10) @(posedge sysClk);
      check(stallCnt, expStall);
      check(redirCnt, expRedir);
      check(tagQ.size(), expQ.size());
      foreach (expQ[i]) check(tagQ[i], expQ[i]);
      $display("test %s done", name);
   endtask : finish_test

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_agload;
      for (int g = 0; g < 3; g++) begin
         start();
         issue(M_LD, UNIT_ALU, 4'h3, 4'h0);
         repeat (g) gap();
         issue(M_IND | M_BR, UNIT_ALU, 4'h0, 4'h3);
         finish_test("agload", 2 - g);
      end
      start();
      issue(M_LD, UNIT_ALU, 4'h3, 4'h0);
      issue(M_IND | M_BR, UNIT_ALU, 4'h0, 4'h5);
      finish_test("agload other reg", 0);
   endtask : t_agload

   task automatic t_flags;
      int e;
      for (int p = 0; p < 3; p++) begin
         for (int c = 0; c < 3; c++) begin
            start();
            e = (p != c) ? 0 : ((c == 1) ? 2 : 1);
            issue(M_SALU << p, UNIT_ALU, 4'h0, 4'h0);
            issue(M_BR | M_CND, bchs_unit_t'(c), 4'h0, 4'h0);
            finish_test("flags", e);
         end
      end
   endtask : t_flags

   task automatic t_loop;
      int e;
      for (int k = 0; k < 3; k++) begin
         start();
         e = (k == 0) ? 2 : ((k == 1) ? 1 : 0);
         issue((k == 2) ? 14'h0000 : M_LCC, UNIT_ALU, 4'h0, 4'h0);
         issue(((k == 1) ? 14'h0000 : M_BR) | M_CND, UNIT_LOOP, 4'h0, 4'h0);
         finish_test("loop count", e);
      end
   endtask : t_loop

   task automatic t_status;
      int n;
      for (int pre = 0; pre < 3; pre++) begin
         for (int post = 0; post < 2; post++) begin
            start();
            n = (pre + post == 0) ? 2 : ((pre + post == 1) ? 1 : 0);
            issue(M_SW, UNIT_ALU, 4'h0, 4'h0);
            repeat (pre) gap();
            issue(M_CPM, UNIT_ALU, 4'h0, 4'h2);
            repeat (post) gap();
            issue(M_IDX, UNIT_ALU, 4'h0, 4'h2);
            finish_test("post modify", n);
         end
      end
   endtask : t_status

   task automatic t_fpmul;
      for (int g = 0; g < 2; g++) begin
         start();
         issue(M_FPM, UNIT_ALU, 4'h0, 4'h0);
         repeat (g) gap();
         issue(M_FXU, UNIT_ALU, 4'h0, 4'h0);
         finish_test("float then fixed", 1 - g);
      end
   endtask : t_fpmul

   // taken branch, plain or flag-conditioned after an alu flag setter; three younger are lost
   task automatic t_taken(input bit withFlag);
      int k;
      start();
      if (withFlag) issue(M_SALU, UNIT_ALU, 4'h0, 4'h0);
      issue(M_TKN | M_BR | (withFlag ? M_CND : 14'h0000), UNIT_ALU,
            4'h0, 4'h0);
      repeat (3) issue(14'h0000, UNIT_ALU, 4'h0, 4'h0, 0);
      fetchValid <= 1'b0;
      k = 0;
      #1;
      while (fetchRedirect !== 1'b1 && k < 8) begin
         @(posedge sysClk);
         #1;
         k++;
      end
      issue(14'h0000, UNIT_ALU, 4'h0, 4'h0);
      k = withFlag;
      finish_test("taken branch", k, 1);
   endtask : t_taken

   // load plus flag producer: stalls overlap, exactly the larger (two) expected
   task automatic t_combined;
      start();
      issue(M_LD | M_SALU, UNIT_ALU, 4'h1, 4'h0);
      issue(M_IND | M_BR | M_CND, UNIT_ALU, 4'h0, 4'h1);
      finish_test("combined", 2);
      check(stallCnt >= 2 && stallCnt <= 3, 1);
   endtask : t_combined

   // ****************************************************************
   // sequence and watchdog
   // ****************************************************************
   initial begin
      repeat (2) @(posedge sysClk);
      rstN <= 1'b1;
      @(posedge sysClk);
      t_agload();
      t_flags();
      t_loop();
      t_status();
      t_fpmul();
      t_taken(0);
      t_taken(1);
      t_combined();
      summarize();
   end

   // whole run needs under a thousand cycles; allow generous margin
   initial begin
      #200000;
      err_count++;
      summarize();
   end

endmodule : test_bchs_core
